// ===== src/rch_regs.vh
`ifndef RCH_REGS_VH
`define RCH_REGS_VH
////////////////////////////////////////////////////////////////////////////////
// register offsets; 0x00-0x05 and 0x30-0x33 are backed up
`define RCH_A_MODE      8'h00
`define RCH_A_LADDR_LO  8'h01
`define RCH_A_LADDR_HI  8'h02
`define RCH_A_GRP_ONE   8'h03
`define RCH_A_GRP_MASK  8'h04
`define RCH_A_THRESH    8'h05
`define RCH_A_TXCMD     8'h06
`define RCH_A_RXCMD     8'h07
`define RCH_A_STAT      8'h08
`define RCH_A_IEN       8'h09
`define RCH_A_VERSION   8'h0a
`define RCH_A_TXGO      8'h0b
`define RCH_A_TXD0      8'h0c
`define RCH_A_TXD1      8'h0d
`define RCH_A_RXD0      8'h0e
`define RCH_A_RXD1      8'h0f
`define RCH_A_USER_LO   8'h30
`define RCH_A_USER_HI   8'h33
////////////////////////////////////////////////////////////////////////////////
// mode register bits
`define RCH_M_TXEN      0
`define RCH_M_EXT       1
`define RCH_M_ACK       2
`define RCH_M_LOCK      3
`define RCH_M_DOFF      4
// status register bits
`define RCH_S_SENT      0
`define RCH_S_RXAV      1
`define RCH_S_NORESP    2
`define RCH_S_NOACK     3
`define RCH_S_BUSY      4
`define RCH_S_VCHG      5
`define RCH_S_USER      6
////////////////////////////////////////////////////////////////////////////////
// command identifiers
`define RCH_C_TXEN      8'h01
`define RCH_C_RESET     8'h02
`define RCH_C_EXT       8'h03
`define RCH_C_SETLA     8'h04
`define RCH_C_GETLA     8'h05
`define RCH_C_GETPA     8'h06
`define RCH_C_GETMODE   8'h07
`define RCH_C_GETVER    8'h08
`define RCH_C_SEND      8'h09
`define RCH_C_REQ       8'h0a
`define RCH_C_RESP      8'h0b
`define RCH_C_DET       8'h0c
`define RCH_C_THR       8'h0d
`define RCH_C_SETGRP    8'h0e
`define RCH_C_GETGRP    8'h0f
`define RCH_C_USER      8'h30
// reply codes
`define RCH_R_OK        8'h00
`define RCH_R_DENY      8'h01
// selectable slave addresses
`define RCH_SLV_LO      7'h01
`define RCH_SLV_HI      7'h7a
////////////////////////////////////////////////////////////////////////////////
// reset values and timing
`define RCH_MODE_RST    8'h01
`define RCH_CLK_HZ      10000000
`define RCH_ACK_MS      500
`define RCH_RESP_MS     1500
`define RCH_ACK_CYC     (`RCH_ACK_MS * (`RCH_CLK_HZ / 1000))
`define RCH_RESP_CYC    (`RCH_RESP_MS * (`RCH_CLK_HZ / 1000))
`endif

// ===== src/rch_top.v
`include "rch_regs.vh"

// Behaviour
// - slave address picked by select pin
// - send tx code, store received code
// - control commands applied when unlocked, replied
// - data commands acked in ack mode, notified
// - no ack within 500 ms flagged
// - response within 1.5 s flags success
// - no response within 1.5 s flagged
// - status bits, interrupt gated by enable
// - codes 0x30 and up go to host
// - remote reset reloads backed registers, idles
// - remote tx enable touches only that bit
// - set replies 00 unlocked, 01 locked
// - remote extended addressing bit applied
// - logical address 8 or 16 bits adopted
// - logical address returned if tx enabled
// - physical address returned if tx enabled
// - mode register returned if tx enabled
// - version returned if tx enabled
// - send data carries tx data, ack optional
// - remote detector enable applied under lock
// - remote 3-bit threshold applied under lock
// - remote group bytes adopted
module rch_top #(
  parameter [31:0] ACK_TIMEOUT_CYC  = `RCH_ACK_CYC,
  parameter [31:0] RESP_TIMEOUT_CYC = `RCH_RESP_CYC,
  parameter        TMR_W            = 24,
  parameter [7:0]  VERSION          = 8'h01,  // arbitrary value
  parameter [63:0] PHYS_ADDR        = 64'h0   // arbitrary value
) (
  // clock and reset
  input  wire        CLK_I,
  input  wire        SYS_RST_I,
  // register port
  input  wire [7:0]  REG_ADDR_I,
  input  wire [7:0]  REG_WDATA_I,
  input  wire        REG_WR_I,
  input  wire        REG_RD_I,
  output wire [7:0]  REG_RDATA_O,
  // slave address selection
  input  wire        ADDR_SEL_I,
  output wire [6:0]  SLV_ADDR_O,
  // received commands from network layer
  input  wire        RX_VALID_I,
  input  wire [7:0]  RX_CMD_I,
  input  wire [15:0] RX_PAYLOAD_I,
  input  wire        RX_ACK_I,
  // transmit requests to network layer
  output wire        TX_REQ_O,
  output wire        TX_REPLY_O,
  output wire        TX_ACK_O,
  output wire [7:0]  TX_CMD_O,
  output wire [3:0]  TX_LEN_O,
  output wire [63:0] TX_DATA_O,
  input  wire        TX_DONE_I,
  // host notification and detector settings
  output wire        HOST_INT_O,
  output wire        DETECT_OFF_O,
  output wire [2:0]  THRESH_O
);

  ////////////////////////////////////////////////////////////////////////////
  // transfer states
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_WDONE = 2'd1;
  localparam [1:0] ST_WACK  = 2'd2;
  localparam [1:0] ST_WRESP = 2'd3;
  localparam [TMR_W-1:0] TMR_ONE = {{(TMR_W-1){1'b0}}, 1'b1};

  // map an address onto the backed-up storage slot, 15 if none
  function [3:0] bk_idx;
    input [7:0] a;
    begin
      if (a <= `RCH_A_THRESH)
        bk_idx = a[3:0];
      else if (a >= `RCH_A_USER_LO && a <= `RCH_A_USER_HI)
        bk_idx = {2'b01, a[1:0]} + 4'd2;
      else
        bk_idx = 4'hf;
    end
  endfunction

  // set commands answer with a lock code
  function is_set;
    input [7:0] c;
    begin
      is_set = (c >= `RCH_C_TXEN && c <= `RCH_C_SETLA) ||
               (c >= `RCH_C_DET && c <= `RCH_C_SETGRP);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage
  reg  [7:0]       cfg [0:9];      // live backed registers
  reg  [7:0]       bk  [0:9];      // nonvolatile copies
  reg  [7:0]       tx_cmd_code_reg; // command to send
  reg  [7:0]       rx_cmd_code_reg; // last received command
  reg  [7:0]       int_stat;       // sticky status
  reg  [7:0]       int_en;         // interrupt enables
  reg  [7:0]       tx_d0;          // local tx data byte 0
  reg  [7:0]       tx_d1;          // local tx data byte 1
  reg  [7:0]       rx_d0;          // received data byte 0
  reg  [7:0]       rx_d1;          // received data byte 1
  reg  [1:0]       state;          // transfer state
  reg  [TMR_W-1:0] tmr;            // timeout down counter
  reg              cur_ack;        // send was in ack mode
  reg              cur_req;        // send was a request
  reg              sel_s1;         // select pin sync stage 1
  reg              sel_s2;         // select pin sync stage 2
  reg  [6:0]       slv_addr;       // chosen slave address
  reg  [7:0]       rdata;          // read data
  reg              host_int;       // interrupt pin
  reg              tx_req;         // transmit pulse
  reg              tx_reply;       // transmit is an answer
  reg              tx_ack;         // transmit is an ack packet
  reg  [7:0]       tx_cmd;         // transmitted code
  reg  [3:0]       tx_len;         // payload bytes
  reg  [63:0]      tx_data;        // payload
  integer          i;

  wire [7:0] node_mode_reg = cfg[0];
  wire       tx_en   = node_mode_reg[`RCH_M_TXEN];
  wire       ext     = node_mode_reg[`RCH_M_EXT];
  wire       lock    = node_mode_reg[`RCH_M_LOCK];
  wire [3:0] wr_idx  = bk_idx(REG_ADDR_I);
  wire       tmr_end = (tmr == {TMR_W{1'b0}});

  ////////////////////////////////////////////////////////////////////////////
  // decode of received commands, replies and status events
  reg        rep_go;    // answer the initiator
  reg        rep_ack;   // answer is an ack packet
  reg [3:0]  rep_len;   // answer length
  reg [63:0] rep_data;  // answer payload
  reg        apply;     // change configuration
  reg        host_go;   // host asks to send
  reg        send_ok;   // host send accepted
  reg        got_resp;  // awaited response arrived
  reg [7:0]  set_st;    // status bits to set
  reg [7:0]  rd_mux;    // read selection

  always @*
  begin
    rep_go   = 1'b0;
    rep_ack  = 1'b0;
    rep_len  = 4'h0;
    rep_data = 64'h0;
    apply    = 1'b0;
    got_resp = 1'b0;
    set_st   = 8'h00;
    if (RX_VALID_I)
    begin
      if (is_set(RX_CMD_I))
      begin
        rep_go   = 1'b1;
        rep_len  = 4'h1;
        rep_data = {56'h0, lock ? `RCH_R_DENY : `RCH_R_OK};
        apply    = !lock;
        set_st[`RCH_S_VCHG] = 1'b1;
      end
      else if ((RX_CMD_I >= `RCH_C_GETLA && RX_CMD_I <= `RCH_C_GETVER) ||
               RX_CMD_I == `RCH_C_GETGRP)
      begin
        rep_go = tx_en;
        set_st[`RCH_S_VCHG] = 1'b1;
        case (RX_CMD_I)
          `RCH_C_GETLA:
          begin
            rep_len  = ext ? 4'h2 : 4'h1;
            rep_data = {48'h0, ext ? cfg[2] : 8'h00, cfg[1]};
          end
          `RCH_C_GETPA:
          begin
            rep_len  = 4'h8;
            rep_data = PHYS_ADDR;
          end
          `RCH_C_GETMODE:
          begin
            rep_len  = 4'h1;
            rep_data = {56'h0, node_mode_reg};
          end
          `RCH_C_GETVER:
          begin
            rep_len  = 4'h1;
            rep_data = {56'h0, VERSION};
          end
          default:
          begin
            rep_len  = 4'h2;
            rep_data = {48'h0, cfg[4], cfg[3]};
          end
        endcase
      end
      else if (RX_CMD_I == `RCH_C_SEND || RX_CMD_I == `RCH_C_REQ)
      begin
        rep_go  = node_mode_reg[`RCH_M_ACK];
        rep_ack = 1'b1;
        set_st[`RCH_S_RXAV] = 1'b1;
      end
      else if (RX_CMD_I == `RCH_C_RESP)
      begin
        got_resp = (state == ST_WRESP);
        set_st[`RCH_S_RXAV] = 1'b1;
        set_st[`RCH_S_SENT] = got_resp;
      end
      else if (RX_CMD_I >= `RCH_C_USER)
      begin
        set_st[`RCH_S_RXAV] = 1'b1;
        set_st[`RCH_S_USER] = 1'b1;
      end
    end
    // reserved codes fall through with no reply or status; only the received code register takes them
    host_go = REG_WR_I && (REG_ADDR_I == `RCH_A_TXGO);
    // a reply owns the transmit port this cycle, so the send is refused
    send_ok = host_go && (state == ST_IDLE) && tx_en && !rep_go;
    if (host_go && !send_ok)
      set_st[`RCH_S_BUSY] = 1'b1;
    if (state == ST_WDONE && TX_DONE_I && !cur_ack && !cur_req)
      set_st[`RCH_S_SENT] = 1'b1;
    if (state == ST_WACK && RX_ACK_I && !cur_req)
      set_st[`RCH_S_SENT] = 1'b1;
    if (state == ST_WACK && !RX_ACK_I && tmr_end)
      set_st[`RCH_S_NOACK] = 1'b1;
    if (state == ST_WRESP && !got_resp && tmr_end)
      set_st[`RCH_S_NORESP] = 1'b1;
  end

  // read selection, unmapped reads zero
  always @*
  begin
    case (REG_ADDR_I)
      `RCH_A_TXCMD:   rd_mux = tx_cmd_code_reg;
      `RCH_A_RXCMD:   rd_mux = rx_cmd_code_reg;
      `RCH_A_STAT:    rd_mux = int_stat;
      `RCH_A_IEN:     rd_mux = int_en;
      `RCH_A_VERSION: rd_mux = VERSION;
      `RCH_A_TXD0:    rd_mux = tx_d0;
      `RCH_A_TXD1:    rd_mux = tx_d1;
      `RCH_A_RXD0:    rd_mux = rx_d0;
      `RCH_A_RXD1:    rd_mux = rx_d1;
      default:        rd_mux = (wr_idx == 4'hf) ? 8'h00 : cfg[wr_idx];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // slave address select, pin passes two flops first
  always @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      sel_s1   <= 1'b0;
      sel_s2   <= 1'b0;
      slv_addr <= `RCH_SLV_LO;
    end
    else
    begin
      sel_s1   <= ADDR_SEL_I;
      sel_s2   <= sel_s1;
      slv_addr <= sel_s2 ? `RCH_SLV_HI : `RCH_SLV_LO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, transfer sequencing and transmit port
  always @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      for (i = 0; i < 10; i = i + 1)
      begin
        cfg[i] <= (i == 0) ? `RCH_MODE_RST : 8'h00;
        bk[i]  <= (i == 0) ? `RCH_MODE_RST : 8'h00;
      end
      tx_cmd_code_reg <= 8'h00;
      rx_cmd_code_reg <= 8'h00;
      int_stat <= 8'h00;
      int_en   <= 8'h00;
      tx_d0    <= 8'h00;
      tx_d1    <= 8'h00;
      rx_d0    <= 8'h00;
      rx_d1    <= 8'h00;
      state    <= ST_IDLE;
      tmr      <= {TMR_W{1'b0}};
      cur_ack  <= 1'b0;
      cur_req  <= 1'b0;
      rdata    <= 8'h00;
      host_int <= 1'b0;
      tx_req   <= 1'b0;
      tx_reply <= 1'b0;
      tx_ack   <= 1'b0;
      tx_cmd   <= 8'h00;
      tx_len   <= 4'h0;
      tx_data  <= 64'h0;
    end
    else
    begin
      // read data valid only the cycle after the strobe
      rdata  <= REG_RD_I ? rd_mux : 8'h00;
      tx_req <= 1'b0;
      // host writes; backed registers also refresh their copy
      if (REG_WR_I)
      begin
        if (wr_idx != 4'hf)
        begin
          cfg[wr_idx] <= REG_WDATA_I;
          bk[wr_idx]  <= REG_WDATA_I;
        end
        case (REG_ADDR_I)
          `RCH_A_TXCMD: tx_cmd_code_reg <= REG_WDATA_I;
          `RCH_A_IEN:   int_en <= REG_WDATA_I;
          `RCH_A_TXD0:  tx_d0 <= REG_WDATA_I;
          `RCH_A_TXD1:  tx_d1 <= REG_WDATA_I;
          default:      ;
        endcase
      end
      // write one clears, a new event wins
      int_stat <= (int_stat & ~((REG_WR_I && REG_ADDR_I == `RCH_A_STAT) ?
                  REG_WDATA_I : 8'h00)) | set_st;
      host_int <= |(int_stat & int_en);
      if (RX_VALID_I)
      begin
        rx_cmd_code_reg <= RX_CMD_I;
        if (RX_CMD_I >= `RCH_C_SEND && RX_CMD_I <= `RCH_C_RESP ||
            RX_CMD_I >= `RCH_C_USER)
        begin
          rx_d0 <= RX_PAYLOAD_I[7:0];
          rx_d1 <= RX_PAYLOAD_I[15:8];
        end
      end
      // transfer sequencing with timeouts
      case (state)
        ST_IDLE:
          if (send_ok)
          begin
            state    <= ST_WDONE;
            cur_ack  <= node_mode_reg[`RCH_M_ACK];
            cur_req  <= (tx_cmd_code_reg == `RCH_C_REQ);
            tx_req   <= 1'b1;
            tx_reply <= 1'b0;
            tx_ack   <= 1'b0;
            tx_cmd   <= tx_cmd_code_reg;
            tx_len   <= 4'h2;
            tx_data  <= {48'h0, tx_d1, tx_d0};
          end
        ST_WDONE:
          if (TX_DONE_I)
          begin
            if (cur_ack)
            begin
              state <= ST_WACK;
              tmr   <= ACK_TIMEOUT_CYC[TMR_W-1:0] - TMR_ONE;
            end
            else if (cur_req)
            begin
              state <= ST_WRESP;
              tmr   <= RESP_TIMEOUT_CYC[TMR_W-1:0] - TMR_ONE;
            end
            else
              state <= ST_IDLE;
          end
        ST_WACK:
          if (RX_ACK_I)
          begin
            state <= cur_req ? ST_WRESP : ST_IDLE;
            tmr   <= RESP_TIMEOUT_CYC[TMR_W-1:0] - TMR_ONE;
          end
          else if (tmr_end)
            state <= ST_IDLE;
          else
            tmr <= tmr - TMR_ONE;
        ST_WRESP:
          if (got_resp || tmr_end)
            state <= ST_IDLE;
          else
            tmr <= tmr - TMR_ONE;
        default:
          state <= ST_IDLE;
      endcase
      // answers to the initiator; set and ack answers ignore tx enable, get answers need it
      if (rep_go)
      begin
        tx_req   <= 1'b1;
        tx_reply <= 1'b1;
        tx_ack   <= rep_ack;
        tx_cmd   <= RX_CMD_I;
        tx_len   <= rep_ack ? 4'h0 : rep_len;
        tx_data  <= rep_ack ? 64'h0 : rep_data;
      end
      // remote configuration changes override a host write
      if (apply)
      begin
        case (RX_CMD_I)
          `RCH_C_TXEN: cfg[0][`RCH_M_TXEN] <= RX_PAYLOAD_I[0];
          `RCH_C_EXT:  cfg[0][`RCH_M_EXT] <= RX_PAYLOAD_I[0];
          `RCH_C_SETLA:
          begin
            cfg[1] <= RX_PAYLOAD_I[7:0];
            if (ext)
              cfg[2] <= RX_PAYLOAD_I[15:8];
          end
          `RCH_C_DET:  cfg[0][`RCH_M_DOFF] <= RX_PAYLOAD_I[0];
          `RCH_C_THR:  cfg[5] <= {5'h00, RX_PAYLOAD_I[2:0]};
          `RCH_C_SETGRP:
          begin
            cfg[3] <= RX_PAYLOAD_I[7:0];
            cfg[4] <= RX_PAYLOAD_I[15:8];
          end
          `RCH_C_RESET:
          begin
            for (i = 0; i < 10; i = i + 1)
              cfg[i] <= bk[i];
            tx_cmd_code_reg <= 8'h00;
            int_stat <= set_st;
            int_en   <= 8'h00;
            tx_d0    <= 8'h00;
            tx_d1    <= 8'h00;
            rx_d0    <= 8'h00;
            rx_d1    <= 8'h00;
            state    <= ST_IDLE;
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops
  assign REG_RDATA_O  = rdata;
  assign SLV_ADDR_O   = slv_addr;
  assign TX_REQ_O     = tx_req;
  assign TX_REPLY_O   = tx_reply;
  assign TX_ACK_O     = tx_ack;
  assign TX_CMD_O     = tx_cmd;
  assign TX_LEN_O     = tx_len;
  assign TX_DATA_O    = tx_data;
  assign HOST_INT_O   = host_int;
  assign DETECT_OFF_O = cfg[0][`RCH_M_DOFF];
  assign THRESH_O     = cfg[5][2:0];

endmodule // rch_top

// ===== testbench/rch_top_monitor.sv
module rch_top_monitor #(
  parameter [7:0]  VERSION   = 8'h01,
  parameter [63:0] PHYS_ADDR = 64'h0
) (
  // clock and reset
  input wire        CLK_I,
  input wire        SYS_RST_I,
  // register port and address pin
  input wire        REG_RD_I,
  input wire [7:0]  REG_RDATA_O,
  input wire        ADDR_SEL_I,
  input wire [6:0]  SLV_ADDR_O,
  // network side
  input wire        RX_VALID_I,
  input wire [7:0]  RX_CMD_I,
  input wire        TX_REQ_O,
  input wire        TX_REPLY_O,
  input wire        TX_ACK_O,
  input wire [7:0]  TX_CMD_O,
  input wire [3:0]  TX_LEN_O,
  input wire [63:0] TX_DATA_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // set-type codes always get a one-byte verdict
  wire set_cmd = RX_VALID_I && (RX_CMD_I inside {[8'h01:8'h04], [8'h0c:8'h0e]});
  // codes that must never draw an answer
  wire quiet_cmd = RX_VALID_I && (RX_CMD_I >= 8'h30 || RX_CMD_I == 8'h0b
                   || RX_CMD_I == 8'h00 || RX_CMD_I inside {[8'h10:8'h2f]});
  ////////////////////////////////////////////////////////////////////////////
  a_addr_pin_low: assert property (!ADDR_SEL_I [*5] |-> SLV_ADDR_O == 7'h01)
    else $error("slave address not low choice");
  a_addr_pin_high: assert property (ADDR_SEL_I [*5] |-> SLV_ADDR_O == 7'h7a)
    else $error("slave address not high choice");
  a_set_reply: assert property (set_cmd |=> TX_REQ_O && TX_REPLY_O && !TX_ACK_O
    && TX_CMD_O == $past(RX_CMD_I) && TX_LEN_O == 4'h1 && TX_DATA_O[63:1] == 63'h0)
    else $error("set command reply malformed");
  a_quiet_codes: assert property (quiet_cmd |=> !(TX_REQ_O && TX_REPLY_O))
    else $error("unexpected answer to quiet code");
  a_ack_empty: assert property (TX_REQ_O && TX_ACK_O |-> TX_REPLY_O
    && TX_LEN_O == 4'h0 && TX_DATA_O == 64'h0) else $error("ack packet not empty");
  a_rdata_idle: assert property (!REG_RD_I |=> REG_RDATA_O == 8'h00)
    else $error("read data outside read slot");
  a_phys_reply: assert property (RX_VALID_I && RX_CMD_I == 8'h06 |=> !TX_REQ_O
    || (TX_LEN_O == 4'h8 && TX_DATA_O == PHYS_ADDR)) else $error("bad physical address reply");
  a_version_reply: assert property (RX_VALID_I && RX_CMD_I == 8'h08 |=> !TX_REQ_O
    || (TX_LEN_O == 4'h1 && TX_DATA_O[7:0] == VERSION)) else $error("bad version reply");
  a_data_ack: assert property (RX_VALID_I && RX_CMD_I == 8'h09 |=> !TX_REQ_O
    || !TX_REPLY_O || TX_ACK_O) else $error("data command answered without ack");
endmodule // rch_top_monitor

// ===== testbench/rch_net_model.sv
module rch_net_model (
  // clock and reset
  input  wire  clk_i,
  input  wire  rst_i,
  // transmit side of the handler
  input  wire  tx_req_i,
  input  wire  tx_reply_i,
  input  wire  ack_en_i,
  // completion and acknowledgement back
  output logic tx_done_o,
  output logic rx_ack_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;  // cycles since our own frame started
  ////////////////////////////////////////////////////////////////////////////
  // replies get no done; a lost ack is the only fault, set by ack_en_i
  always @(posedge clk_i)
  begin
    tx_done_o <= 1'b0;
    rx_ack_o  <= 1'b0;
    if (rst_i)
      cnt <= 0;
    else if (tx_req_i && !tx_reply_i)
      cnt <= 1;
    else if (cnt != 0)
    begin
      cnt <= cnt + 1;
      if (cnt == 4)
        tx_done_o <= 1'b1;
      if (cnt == 7)
      begin
        rx_ack_o <= ack_en_i;
        cnt      <= 0;
      end
    end
  end
endmodule // rch_net_model

// ===== testbench/rch_top_bench.sv
module rch_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [7:0]  VER = 8'h5a;                   // arbitrary value
  localparam [63:0] PA  = 64'h0123456789abcdef;    // arbitrary value
  logic clk = 0, rst = 1, wr_s = 0, rd_s = 0, sel = 0, rxv = 0, ack_en = 0;
  logic [7:0] addr = 0, wdata = 0, rxcmd = 0, rdata, txcmd;
  logic [15:0] rxpl = 0;
  logic [6:0] slv;
  logic [3:0] txlen;
  logic [63:0] txdata;
  logic [2:0] thr;
  logic txreq, txrep, txack, done, rxack, hint, doff;
  int errors = 0, compares = 0;
  always #50 clk = ~clk;
  rch_top #(.ACK_TIMEOUT_CYC(20), .RESP_TIMEOUT_CYC(40), .VERSION(VER), .PHYS_ADDR(PA))
  rch_top_i (.CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata), .ADDR_SEL_I(sel),
    .SLV_ADDR_O(slv), .RX_VALID_I(rxv), .RX_CMD_I(rxcmd), .RX_PAYLOAD_I(rxpl),
    .RX_ACK_I(rxack), .TX_REQ_O(txreq), .TX_REPLY_O(txrep), .TX_ACK_O(txack),
    .TX_CMD_O(txcmd), .TX_LEN_O(txlen), .TX_DATA_O(txdata), .TX_DONE_I(done),
    .HOST_INT_O(hint), .DETECT_OFF_O(doff), .THRESH_O(thr));
  rch_net_model rch_net_model_i (.clk_i(clk), .rst_i(rst), .tx_req_i(txreq),
    .tx_reply_i(txrep), .ack_en_i(ack_en), .tx_done_o(done), .rx_ack_o(rxack));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(v, e);
  endtask
  task automatic rx(input logic [7:0] c, input logic [15:0] p);
    @(posedge clk);
    rxv <= 1'b1;
    rxcmd <= c;
    rxpl <= p;
    @(posedge clk);
    rxv <= 1'b0;
    #1;
  endtask
  task automatic txc(input logic r, input logic [7:0] c, input logic [3:0] l,
                     input logic [63:0] d);
    chk(txreq, r);
    if (r)
    begin
      chk(txcmd, c);
      chk(txlen, l);
      chk(txdata, d);
    end
  endtask
  // poll status until a masked bit shows, then compare it whole
  task automatic ws(input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    for (int i = 0; i < 80; i++)
    begin
      rd(8'h08, v);
      if ((v & m) != 0)
        break;
    end
    chk(v, e);
  endtask
  task automatic conclude;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h00, 8'h01);
    chk(slv, 7'h01);
    @(posedge clk) sel <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk(slv, 7'h7a);
    rdc(8'h20, 8'h00);
    wr(8'h0a, 8'hff);
    rdc(8'h0a, VER);
    rx(8'h04, 16'h0055); txc(1, 8'h04, 1, 0);
    rdc(8'h01, 8'h55);
    rdc(8'h07, 8'h04);
    rx(8'h01, 16'h0); txc(1, 8'h01, 1, 0); rdc(8'h00, 8'h00);
    rx(8'h07, 16'h0); txc(0, 0, 0, 0);
    rx(8'h01, 16'h1); txc(1, 8'h01, 1, 0); rdc(8'h00, 8'h01);
    rx(8'h06, 16'h0); txc(1, 8'h06, 8, PA);
    rx(8'h08, 16'h0); txc(1, 8'h08, 1, VER);
    rx(8'h07, 16'h0); txc(1, 8'h07, 1, 1);
    rx(8'h03, 16'h1); txc(1, 8'h03, 1, 0); rdc(8'h00, 8'h03);
    rx(8'h04, 16'h1234); txc(1, 8'h04, 1, 0);
    rx(8'h05, 16'h0); txc(1, 8'h05, 2, 64'h1234);
    wr(8'h00, 8'h09);
    rx(8'h0d, 16'h5); txc(1, 8'h0d, 1, 1); chk(thr, 0);
    wr(8'h00, 8'h01);
    rx(8'h0d, 16'h5); txc(1, 8'h0d, 1, 0); chk(thr, 5);
    rx(8'h0c, 16'h1); txc(1, 8'h0c, 1, 0); chk(doff, 1);
    rx(8'h0e, 16'ha503); txc(1, 8'h0e, 1, 0); rdc(8'h04, 8'ha5);
    rx(8'h0f, 16'h0); txc(1, 8'h0f, 2, 64'ha503);
    wr(8'h08, 8'hff);
    rx(8'h30, 16'h00c3); txc(0, 0, 0, 0); rdc(8'h0e, 8'hc3);
    rdc(8'h07, 8'h30); rdc(8'h08, 8'h42);
    rx(8'h20, 16'hffff); txc(0, 0, 0, 0); rdc(8'h00, 8'h11);
    rdc(8'h07, 8'h20); rdc(8'h08, 8'h42);
    wr(8'h08, 8'hff);
    wr(8'h09, 8'h20);
    rx(8'h01, 16'h1);
    @(posedge clk);
    #1 chk(hint, 1);
    wr(8'h08, 8'hff);
    @(posedge clk);
    #1 chk(hint, 0);
    wr(8'h09, 8'h00);
    rx(8'h01, 16'h1);
    @(posedge clk);
    #1 chk(hint, 0);
    wr(8'h08, 8'hff);
    wr(8'h06, 8'h09);
    wr(8'h0c, 8'h11);
    wr(8'h0d, 8'h22);
    wr(8'h0b, 8'h00);
    #1 txc(1, 8'h09, 2, 64'h2211); chk(txrep, 0);
    ws(8'h01, 8'h01);
    wr(8'h00, 8'h05);
    wr(8'h08, 8'hff);
    wr(8'h0b, 8'h00);
    ws(8'h08, 8'h08);
    ack_en <= 1'b1;
    wr(8'h08, 8'hff);
    wr(8'h0b, 8'h00);
    ws(8'h09, 8'h01);
    wr(8'h08, 8'hff);
    rx(8'h09, 16'h3344); txc(1, 8'h09, 0, 0); chk(txack, 1);
    rdc(8'h0e, 8'h44); rdc(8'h08, 8'h02);
    wr(8'h00, 8'h01);
    wr(8'h06, 8'h0a);
    wr(8'h08, 8'hff);
    wr(8'h0b, 8'h00);
    ws(8'h04, 8'h04);
    wr(8'h08, 8'hff);
    wr(8'h0b, 8'h00);
    repeat (10) @(posedge clk);
    rx(8'h0b, 16'h0077); txc(0, 0, 0, 0);
    ws(8'h01, 8'h03);
    wr(8'h01, 8'h77);
    rx(8'h04, 16'h0099); rdc(8'h01, 8'h99);
    rx(8'h02, 16'h0); txc(1, 8'h02, 1, 0);
    rdc(8'h01, 8'h77); rdc(8'h00, 8'h01); rdc(8'h07, 8'h02);
    wr(8'h08, 8'hff);
    wr(8'h00, 8'h00);
    wr(8'h0b, 8'h00);
    #1 txc(0, 0, 0, 0); rdc(8'h08, 8'h10);
    conclude();
  end
  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule // rch_top_bench

bind rch_top rch_top_monitor #(.VERSION(VERSION), .PHYS_ADDR(PHYS_ADDR)) rch_top_monitor_i (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .ADDR_SEL_I(ADDR_SEL_I), .SLV_ADDR_O(SLV_ADDR_O), .RX_VALID_I(RX_VALID_I),
  .RX_CMD_I(RX_CMD_I), .TX_REQ_O(TX_REQ_O), .TX_REPLY_O(TX_REPLY_O), .TX_ACK_O(TX_ACK_O),
  .TX_CMD_O(TX_CMD_O), .TX_LEN_O(TX_LEN_O), .TX_DATA_O(TX_DATA_O));
